// *** mcss_chk_assertions.sv ***
// Purpose: port checks of the clock select block
// Assumes: one clock, async active low reset
// Notes: bound into mcss_top
`default_nettype none
module mcss_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_power_control_register_idle,
    input wire logic i_wakeup,
    input wire logic o_ring_osc_run,
    input wire logic o_xtal_run,
    input wire logic o_switch_busy,
    input wire logic o_sleeping
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // bus answers after one wait cycle
    a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("wait cycle count wrong");
    a_wait_low_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_read_unused_zero: assert property (!o_avs_waitrequest |->
        o_avs_readdata[31:8] == 24'h00_0000 && o_avs_readdata[1:0] == 2'h0)
        else $error("unused read bits set");
    // ring gated first, then everything stops
    a_stop_order: assert property ($rose(o_sleeping) |->
        !o_xtal_run && $past(o_ring_osc_run) == 1'b0) else $error("stop order wrong");
    a_stop_idle: assert property ($rose(o_sleeping) |-> $past(i_power_control_register_idle, 2))
        else $error("stopped without idle");
    a_stop_all: assert property (o_sleeping |-> !o_ring_osc_run && !o_xtal_run)
        else $error("oscillator runs while stopped");
    a_wake_run: assert property (o_sleeping && i_wakeup && !i_avs_write |=>
        o_ring_osc_run && o_xtal_run && !o_sleeping) else $error("wakeup missed");
    // a switch is bounded both ways
    a_switch_end: assert property ($rose(o_switch_busy) |-> ##[1:250] !o_switch_busy)
        else $error("switch never ends");
    a_switch_min: assert property ($rose(o_switch_busy) |-> o_switch_busy[*4])
        else $error("switch too short");
    c_sleep: cover property ($rose(o_sleeping));
    c_switch: cover property ($rose(o_switch_busy));
    c_wake: cover property (o_sleeping && i_wakeup);
endmodule // mcss_chk
bind mcss_top mcss_chk u_chk (.i_clk, .i_resetn, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_power_control_register_idle, .i_wakeup, .o_ring_osc_run, .o_xtal_run, .o_switch_busy,
    .o_sleeping);
`default_nettype wire

// *** mcss_clock_switch.sv ***
// Purpose: glitch-free switch between five sampled clock source levels
// Assumes: source levels are synchronous samples taken on i_clk
// Notes: output changes source only while it is low, so no runt pulse
`include "mcss_map.svh"
`default_nettype none

module mcss_clock_switch
    import mcss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [4:0] i_src_lvl,
    input wire mcss_src_t i_target,
    input wire logic i_stop,
    output logic o_clk,
    output logic o_busy
);
    mcss_sw_e state_q, state_d;
    mcss_src_t cur_q, cur_d;
    logic [1:0] cnt_q, cnt_d;
    logic [4:0] prev_q;
    logic clk_q, clk_d;
    logic gate_q, gate_d;
    logic cur_fall;

    // falling edge of the source currently named by cur_q
    assign cur_fall = prev_q[cur_q] & ~i_src_lvl[cur_q];

    // next state: 3 old clocks, park low, 3 new clocks, then pass
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        cnt_d = cnt_q;
        gate_d = gate_q;
        case (state_q)
            MCSS_SW_RUN: begin
                // stop and restart only take effect at a low level
                if (!i_src_lvl[cur_q]) begin
                    gate_d = ~i_stop; // R14
                end
                if (i_target != cur_q && !i_stop) begin
                    state_d = MCSS_SW_OLD; // R9
                    cnt_d = 2'h0;
                end
            end
            MCSS_SW_OLD: begin
                if (cur_fall) begin
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q + 2'h1 == `MCSS_SWITCH_CYCLES) begin
                        state_d = MCSS_SW_NEW; // R9
                        cur_d = i_target;
                        cnt_d = 2'h0;
                        gate_d = 1'b0; // R14
                    end
                end
            end
            MCSS_SW_NEW: begin
                if (cur_fall) begin
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q + 2'h1 == `MCSS_SWITCH_CYCLES) begin
                        state_d = MCSS_SW_RUN; // R9
                        cnt_d = 2'h0;
                        gate_d = ~i_stop; // R14
                    end
                end
            end
            default: begin
                state_d = MCSS_SW_RUN;
            end
        endcase
        // gated output low whenever the gate is shut
        clk_d = gate_d & i_src_lvl[cur_d];
    end

    // registers of the switch
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= MCSS_SW_RUN;
            cur_q <= 3'h0;
            cnt_q <= 2'h0;
            prev_q <= 5'h00;
            clk_q <= 1'b0;
            gate_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            cnt_q <= cnt_d;
            prev_q <= i_src_lvl;
            clk_q <= clk_d;
            gate_q <= gate_d;
        end
    end

    assign o_clk = clk_q;
    assign o_busy = (state_q != MCSS_SW_RUN);
endmodule // mcss_clock_switch

`default_nettype wire

// *** mcss_map.svh ***
// Purpose: register map and field positions of the processor clock select block
// Assumes: byte addressed Avalon-MM slave with 32-bit data
// Notes: printed offset is a register index; byte address is four times it
`ifndef MCSS_MAP_SVH
`define MCSS_MAP_SVH

// register index as printed, and its byte address
`define MCSS_CSS_INDEX 12'h0a5
`define MCSS_CSS_ADDR (`MCSS_CSS_INDEX * 4)
`define MCSS_CSS_RESET 8'h40

// field positions of processor_clock_source_select
`define MCSS_BIT_SLEEP 7
`define MCSS_BIT_RING_EN 6
`define MCSS_BIT_SRC 5
`define MCSS_RATE_HI 4
`define MCSS_RATE_LO 3
`define MCSS_BIT_STABLE 2

// clocks of the old and of the new source spent on a switch
`define MCSS_SWITCH_CYCLES 2'h3

`endif

// *** mcss_pkg.sv ***
// Purpose: types shared by the processor clock select block
// Assumes: nothing beyond the map header
// Notes: source index 0 is the ring oscillator, 1..4 the crystal rates
`default_nettype none

package mcss_pkg;
    // clock source index: ring, 3.75, 7.5, 15, 30 MHz
    typedef logic [2:0] mcss_src_t;

    // power sequence of the sleep control
    typedef enum logic [1:0] {
        MCSS_PWR_RUN = 2'b00,
        MCSS_PWR_GATE_RING = 2'b01,
        MCSS_PWR_STOPPED = 2'b10
    } mcss_pwr_e;

    // phases of the glitch-free source switch
    typedef enum logic [1:0] {
        MCSS_SW_RUN = 2'b00,
        MCSS_SW_OLD = 2'b01,
        MCSS_SW_NEW = 2'b10
    } mcss_sw_e;
endpackage

`default_nettype wire

// *** mcss_src_model.sv ***
// Purpose: clock sources seen by the clock select block
// Assumes: levels sampled on i_clk, periods ring 12, crystal 2/4/8/16
// Notes: a stopped source stands still at its last level
`default_nettype none
module mcss_src_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ring_run,
    input wire logic i_xtal_run,
    output logic o_ring_lvl,
    output logic [3:0] o_xtal_lvl
);
    logic [3:0] ring_q;
    logic [3:0] xtal_q;
    // oscillators run only while enabled
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ring_q <= 4'h0;
            xtal_q <= 4'h0;
        end else begin
            if (i_ring_run) begin
                ring_q <= (ring_q == 4'hb) ? 4'h0 : ring_q + 4'h1;
            end
            if (i_xtal_run) begin
                xtal_q <= xtal_q + 4'h1;
            end
        end
    end
    // bit 0 is the fastest rate
    assign o_ring_lvl = (ring_q < 4'h6);
    assign o_xtal_lvl = xtal_q;
endmodule // mcss_src_model
`default_nettype wire

// *** mcss_tb.sv ***
// Purpose: register level test of the clock select block
// Assumes: 10 mhz clock, sources from mcss_src_model
// Notes: rate checked by counting processor clock rises
`include "mcss_map.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] REG_A = 12'(`MCSS_CSS_ADDR);
    logic i_clk = 1'b0, i_resetn = 1'b0, rd = 1'b0, wr = 1'b0, idle = 1'b0;
    logic wake = 1'b0, stable = 1'b0, seen;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0000_0000, q, rdata, n, error_cnt = 0, checked = 0, tick = 0;
    logic [3:0] be = 4'hf, xlvl;
    logic wreq, ring_run, xtal_run, cpu_clk, busy, sleeping, rlvl;
    mcss_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_power_control_register_idle(idle),
        .i_wakeup(wake), .i_ring_osc_lvl(rlvl), .i_xtal_3m75_lvl(xlvl[3]),
        .i_xtal_7m5_lvl(xlvl[2]), .i_xtal_15m_lvl(xlvl[1]), .i_xtal_30m_lvl(xlvl[0]),
        .i_phy_clocks_stable(stable), .o_ring_osc_run(ring_run), .o_xtal_run(xtal_run),
        .o_cpu_clk(cpu_clk), .o_switch_busy(busy), .o_sleeping(sleeping));
    mcss_src_model u_src (.i_clk(i_clk), .i_resetn(i_resetn), .i_ring_run(ring_run),
        .i_xtal_run(xtal_run), .o_ring_lvl(rlvl), .o_xtal_lvl(xlvl));
    // 100 ns period
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked != 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checked = checked + 1;
        if (seen_v !== exp_v) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen_v, exp_v);
        end
    endtask
    // one access, held until waitrequest is seen low at a rising edge; data taken there
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wd <= {24'h00_0000, d};
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // rises of the processor clock over 96 cycles
    task automatic rises(output logic [31:0] cnt);
        logic prev;
        cnt = 0;
        prev = cpu_clk;
        repeat (96) begin
            @(negedge i_clk);
            if (cpu_clk === 1'b1 && prev === 1'b0) cnt = cnt + 1;
            prev = cpu_clk;
        end
    endtask
    // bounded wait for a switch to start and end
    task automatic wait_sw();
        seen = 1'b0;
        repeat (300) begin
            @(negedge i_clk);
            if (busy === 1'b1) seen = 1'b1;
            else if (seen === 1'b1) break;
        end
    endtask
    // hang guard
    always @(posedge i_clk) begin
        tick <= tick + 1;
        if (tick == 32'h0000_4e20) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        bus(0, REG_A, 8'h00);
        check(q, 32'h0000_0040);
        check(32'({ring_run, xtal_run, sleeping}), 32'h0000_0006);
        bus(1, REG_A + 12'h004, 8'hff);
        bus(0, REG_A + 12'h004, 8'h00);
        check(q, 32'h0000_0000);
        stable <= 1'b1;
        bus(1, REG_A, 8'h43);
        bus(0, REG_A, 8'h00);
        check(q, 32'h0000_0044);
        be <= 4'h0;
        bus(1, REG_A, 8'h00);
        be <= 4'hf;
        bus(0, REG_A, 8'h00);
        check(q, 32'h0000_0044);
        bus(1, REG_A, 8'h04);
        repeat (2) @(negedge i_clk);
        check(32'(ring_run), 32'h0000_0000);
        bus(1, REG_A, 8'h40);
        repeat (2) @(negedge i_clk);
        check(32'(ring_run), 32'h0000_0001);
        repeat (20) @(posedge i_clk);
        // slow to fast with both clocks running and stable seen
        for (int r = 0; r < 4; r++) begin
            bus(1, REG_A, 8'(8'h60 | (r << 3)));
            wait_sw();
            check(32'({seen, busy}), 32'h0000_0002);
            bus(0, REG_A, 8'h00);
            check(q, 32'(8'h64 | (r << 3)));
            rises(n);
            check(n, 32'(6 << r));
        end
        bus(1, REG_A, 8'h58);
        wait_sw();
        rises(n);
        check(n, 32'h0000_0008);
        @(posedge i_clk);
        idle <= 1'b1;
        bus(1, REG_A, 8'hd8);
        repeat (4) @(negedge i_clk);
        check(32'({ring_run, xtal_run, sleeping}), 32'h0000_0001);
        @(posedge i_clk);
        wake <= 1'b1;
        idle <= 1'b0;
        @(posedge i_clk);
        wake <= 1'b0;
        repeat (2) @(negedge i_clk);
        check(32'({ring_run, xtal_run, sleeping}), 32'h0000_0006);
        bus(0, REG_A, 8'h00);
        check(q, 32'h0000_005c);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire

// *** mcss_top.sv ***
// Purpose: processor clock source select, ring enable and sleep control
// Assumes: all inputs synchronous to i_clk; source clocks arrive as sampled levels
// Notes: one register on an Avalon-MM slave with one wait cycle per access
`include "mcss_map.svh"
`default_nettype none

// Operation
// R1: sleep plus idle: gate ring, then stop all
// R2: bit 6 enables or disables ring oscillator
// R3: firmware enables ring before selecting it
// R4: bit 5 zero forces ring, overrides rate
// R5: bits 4:3 choose 3.75/7.5/15/30 MHz
// R6: bit 2 reads live clocks-stable, write ignored
// R7: firmware uses crystal clocks only once stable
// R8: reset value 0x40, ring selected and enabled
// R9: switch takes three old plus three new clocks
// R10: firmware switches only with both clocks running
// R11: firmware may alternate fast and slow clocks
// R12: firmware waits settling after ring enable
// R13: unmasked wakeup restarts ring and crystal oscillators
// R14: switching never emits a short clock pulse
module mcss_top
    import mcss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // processor side
    input wire logic i_power_control_register_idle,
    input wire logic i_wakeup,
    // clock sources, sampled levels
    input wire logic i_ring_osc_lvl,
    input wire logic i_xtal_3m75_lvl,
    input wire logic i_xtal_7m5_lvl,
    input wire logic i_xtal_15m_lvl,
    input wire logic i_xtal_30m_lvl,
    input wire logic i_phy_clocks_stable,
    // oscillator controls and processor clock
    output logic o_ring_osc_run,
    output logic o_xtal_run,
    output logic o_cpu_clk,
    output logic o_switch_busy,
    output logic o_sleeping
);
    // control bits of processor_clock_source_select
    logic sleep_q, sleep_d;
    logic ring_osc_enable_q, ring_osc_enable_d;
    logic processor_clock_source_q, processor_clock_source_d;
    logic [1:0] rate_q, rate_d;

    // bus slave state
    logic waitrequest_q, waitrequest_d;
    logic [31:0] readdata_q, readdata_d;

    // power sequence state
    mcss_pwr_e pwr_q, pwr_d;
    logic ring_run_q, ring_run_d;
    logic xtal_run_q, xtal_run_d;
    logic sleeping_q, sleeping_d;

    // switch wiring
    mcss_src_t target;
    logic sw_stop;
    logic sw_clk;
    logic sw_busy;
    logic busy_q;
    logic [4:0] src_lvl;

    // decoded bus access
    logic hit;
    logic wr_take;
    logic wr_lane0;
    logic [7:0] wbyte;

    // register image that a read returns, with the live stable flag
    logic [7:0] rd_image;

    // reset image; each control bit is cut from it so they cannot drift apart
    localparam logic [7:0] RESET_IMG = `MCSS_CSS_RESET;

    // source index from the select bit and the rate field
    // index 0 is the ring; 1 to 4 run from 3.75 up to 30 mhz
    function automatic mcss_src_t sel_index(input logic src, input logic [1:0] rate);
        mcss_src_t idx;
        idx = 3'h0;
        if (src) begin
            case (rate)
                2'h0: begin
                    idx = 3'h1; // R5
                end
                2'h1: begin
                    idx = 3'h2; // R5
                end
                2'h2: begin
                    idx = 3'h3; // R5
                end
                default: begin
                    idx = 3'h4; // R5
                end
            endcase
        end else begin
            // select bit low wins over whatever the rate field holds
            idx = 3'h0; // R4
        end
        return idx;
    endfunction

    // register image as seen by a read
    function automatic logic [7:0] reg_image(
        input logic slp,
        input logic ren,
        input logic src,
        input logic [1:0] rate,
        input logic stable
    );
        logic [7:0] img;
        img = 8'h00;
        img[`MCSS_BIT_SLEEP] = slp;
        img[`MCSS_BIT_RING_EN] = ren;
        img[`MCSS_BIT_SRC] = src;
        img[`MCSS_RATE_HI:`MCSS_RATE_LO] = rate;
        img[`MCSS_BIT_STABLE] = stable;
        return img;
    endfunction

    // address decode; unmapped reads give zero, unmapped writes vanish
    // full address compared so aliases of the register never answer
    always_comb begin
        if (i_avs_address == 12'(`MCSS_CSS_ADDR)) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // a write lands at the edge where waitrequest is seen low
    assign wr_take = i_avs_write & ~waitrequest_q & hit;
    assign wr_lane0 = wr_take & i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];

    // stable flag is read live and never stored, so a read shows the current level
    always_comb begin
        rd_image = reg_image(sleep_q, ring_osc_enable_q, processor_clock_source_q, rate_q,
            i_phy_clocks_stable); // R6
    end

    // bus answer: one wait cycle, then waitrequest low for one cycle
    always_comb begin
        waitrequest_d = 1'b1;
        readdata_d = readdata_q;
        if ((i_avs_read | i_avs_write) && waitrequest_q) begin
            waitrequest_d = 1'b0;
        end
        if (i_avs_read && waitrequest_q) begin
            readdata_d = 32'h0000_0000;
            if (hit) begin
                readdata_d[7:0] = rd_image; // R6
            end
        end
    end

    // control register next values
    always_comb begin
        sleep_d = sleep_q;
        ring_osc_enable_d = ring_osc_enable_q;
        processor_clock_source_d = processor_clock_source_q;
        rate_d = rate_q;
        // wakeup clears sleep so the core does not drop straight back
        if (pwr_q != MCSS_PWR_RUN && i_wakeup) begin
            sleep_d = 1'b0; // R13
        end
        // a write in the same cycle wins over the hardware clear
        if (wr_lane0) begin
            sleep_d = wbyte[`MCSS_BIT_SLEEP];
            ring_osc_enable_d = wbyte[`MCSS_BIT_RING_EN]; // R2
            processor_clock_source_d = wbyte[`MCSS_BIT_SRC]; // R4
            rate_d = wbyte[`MCSS_RATE_HI:`MCSS_RATE_LO]; // R5
            // stable bit and low bits are read-only, write dropped R6
        end
    end

    // sleep sequence: ring gated first, then every oscillator stopped
    // the switch ignores a stop while mid-way and parks the clock once back in run
    always_comb begin
        pwr_d = pwr_q;
        ring_run_d = ring_run_q;
        xtal_run_d = xtal_run_q;
        case (pwr_q)
            MCSS_PWR_RUN: begin
                ring_run_d = ring_osc_enable_d; // R2
                xtal_run_d = 1'b1;
                if (sleep_q && i_power_control_register_idle) begin
                    pwr_d = MCSS_PWR_GATE_RING; // R1
                    ring_run_d = 1'b0; // R1
                end
            end
            MCSS_PWR_GATE_RING: begin
                if (i_wakeup) begin
                    pwr_d = MCSS_PWR_RUN; // R13
                    ring_run_d = ring_osc_enable_q;
                end else begin
                    pwr_d = MCSS_PWR_STOPPED; // R1
                    xtal_run_d = 1'b0; // R1
                end
            end
            MCSS_PWR_STOPPED: begin
                ring_run_d = 1'b0;
                xtal_run_d = 1'b0;
                if (i_wakeup) begin
                    // both oscillators restart so either source can resume
                    pwr_d = MCSS_PWR_RUN; // R13
                    ring_run_d = 1'b1; // R13
                    xtal_run_d = 1'b1; // R13
                end
            end
            default: begin
                pwr_d = MCSS_PWR_RUN;
                ring_run_d = ring_osc_enable_q;
                xtal_run_d = 1'b1;
            end
        endcase
        // decoded ahead of the edge so the port comes from a flop
        sleeping_d = (pwr_d == MCSS_PWR_STOPPED); // R1
    end

    // control register, reset to 0x40: ring enabled and selected, rate 00
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sleep_q <= RESET_IMG[`MCSS_BIT_SLEEP]; // R8
            ring_osc_enable_q <= RESET_IMG[`MCSS_BIT_RING_EN]; // R8
            processor_clock_source_q <= RESET_IMG[`MCSS_BIT_SRC]; // R8
            rate_q <= RESET_IMG[`MCSS_RATE_HI:`MCSS_RATE_LO]; // R8
        end else begin
            sleep_q <= sleep_d;
            ring_osc_enable_q <= ring_osc_enable_d;
            processor_clock_source_q <= processor_clock_source_d;
            rate_q <= rate_d;
        end
    end

    // bus answer; waitrequest idles high so a request always sees one wait cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            waitrequest_q <= waitrequest_d;
            readdata_q <= readdata_d;
        end
    end

    // power sequence; both oscillators run out of reset so the ring can clock the core
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr_q <= MCSS_PWR_RUN;
            ring_run_q <= 1'b1;
            xtal_run_q <= 1'b1;
            sleeping_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            ring_run_q <= ring_run_d;
            xtal_run_q <= xtal_run_d;
            sleeping_q <= sleeping_d;
        end
    end

    // busy status; one cycle behind the switch, traded for a clean flop on the port
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= sw_busy;
        end
    end

    // source select; relies on firmware having the target running R3 R7 R10
    assign target = sel_index(processor_clock_source_q, rate_q); // R4
    assign sw_stop = (pwr_q != MCSS_PWR_RUN); // R1
    assign src_lvl = {i_xtal_30m_lvl, i_xtal_15m_lvl, i_xtal_7m5_lvl,
        i_xtal_3m75_lvl, i_ring_osc_lvl};

    // glitch-free switch; its output is a flop inside
    // limitation: a source that stops while high leaves the processor clock parked high,
    // and a switch toward a stopped source never ends, so firmware keeps both running
    mcss_clock_switch u_switch (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_src_lvl(src_lvl),
        .i_target(target),
        .i_stop(sw_stop),
        .o_clk(sw_clk),
        .o_busy(sw_busy)
    );

    // outputs straight from flops
    assign o_avs_readdata = readdata_q;
    assign o_avs_waitrequest = waitrequest_q;
    assign o_ring_osc_run = ring_run_q;
    assign o_xtal_run = xtal_run_q;
    assign o_cpu_clk = sw_clk; // R14
    assign o_switch_busy = busy_q;
    assign o_sleeping = sleeping_q;
endmodule // mcss_top

`default_nettype wire
